// file: rtl/xpr_regs.sv
// xpr_regs: control/status register bank and power-mode logic of a 4x4 crosspoint
// assumes: an smbus slave front end delivers decoded byte writes/reads on clk,
// power_down_pin_n, level and boost pins and signal-valid detector levels arrive asynchronously
//
// Contract
// R01: equalization field code 00 off, 01 low, 10 medium, 11 high.
// R02: control bits 3:0 reset to 1111; zero disables that output when powered.
// R03: control bit 4 set makes equalization come from register, not pins.
// R04: control bit 5 set makes pre-emphasis come from register, not pins.
// R05: control bit 6 set enables monitors and receivers on all inputs.
// R06: with monitor enable set, auto gating never disables inputs or monitors.
// R07: control bit 7 soft power-down, or-ed with pin; high either means up.
// R08: both low means power-down, only monitors and smbus logic remain.
// R09: in power-down, monitor enable still activates monitors and receivers.
// R10: when powered up, blocks unused by routing are switched off.
// R11: output enabled only if routed and its output_off_n bit is one.
// R12: input enabled if routed or monitor enable is one.
// R13: status bits 3:0 reset 0, report input signal valid per input.
// R14: status bits 7:4 reserved, read-only; here read as zero.
// R15: control at address 3, status at address 4, byte access.
// R16: equalization register holds four two-bit fields, bits 1:0 for input 0.
// R17: host writes start, address, register byte, data byte, stop.
// R18: writes to status are acknowledged and change nothing.
`timescale 1ns/1ps
`default_nettype none

module xpr_regs (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  input  wire logic        power_down_pin_n,
  input  wire logic [3:0]  rx_level_pins,
  input  wire logic [3:0]  tx_boost_pins,
  input  wire logic [3:0]  input_signal_valid,
  output logic      [3:0]  input_enable,
  output logic      [3:0]  monitor_enable,
  output logic      [3:0]  output_enable,
  output logic             core_powered,
  output logic      [15:0] rx_equalization,
  output logic      [7:0]  tx_pre_emphasis,
  output logic      [7:0]  output_route
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [3:0] level_decode(input logic [1:0] code);
    logic [3:0] lvl;
    lvl = 4'h0;
    case (code)
      xpr_pkg::LVL_CODE_OFF:  lvl = xpr_pkg::XPR_LVL_OFF;  // see R01
      xpr_pkg::LVL_CODE_LOW:  lvl = xpr_pkg::XPR_LVL_LOW;  // see R01
      xpr_pkg::LVL_CODE_MED:  lvl = xpr_pkg::XPR_LVL_MED;  // see R01
      xpr_pkg::LVL_CODE_HIGH: lvl = xpr_pkg::XPR_LVL_HIGH; // see R01
      default:                lvl = xpr_pkg::XPR_LVL_OFF;
    endcase
    return lvl;
  endfunction : level_decode

  // inputs used by at least one output route
  function automatic logic [3:0] routed_inputs(input logic [7:0] route);
    logic [3:0] used;
    used = 4'h0;
    for (int i = 0; i < xpr_pkg::NUM_PORTS; i++) begin
      used[route[2*i +: 2]] = 1'b1;
    end
    return used;
  endfunction : routed_inputs

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change counts once stages two and three agree

  // level and boost pins are asynchronous too, so they share the same filter
  localparam int unsigned PIN_W = 3 * xpr_pkg::NUM_PORTS + 1;

  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] sync3_q;
  logic [PIN_W-1:0] pins_q;
  wire  [PIN_W-1:0] pins_raw = {tx_boost_pins, rx_level_pins, power_down_pin_n, input_signal_valid};

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= {PIN_W{1'b0}};
      sync2_q <= {PIN_W{1'b0}};
      sync3_q <= {PIN_W{1'b0}};
      pins_q  <= {PIN_W{1'b0}};
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int b = 0; b < PIN_W; b++) begin
        if (sync2_q[b] == sync3_q[b]) begin
          pins_q[b] <= sync3_q[b];
        end
      end
    end
  end

  wire       pd_pin_n_s = pins_q[4];
  wire [3:0] valid_s    = pins_q[3:0];
  wire [3:0] lvl_pin_s  = pins_q[8:5];
  wire [3:0] bst_pin_s  = pins_q[12:9];

  //////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] route_q;
  logic [7:0] boost_q;
  logic [7:0] level_q;
  logic [7:0] ctl_q;
  logic [3:0] status_q;

  wire wr_route = wr_stb && (reg_addr == xpr_pkg::ADDR_SWITCH);
  wire wr_boost = wr_stb && (reg_addr == xpr_pkg::ADDR_BOOST);
  wire wr_level = wr_stb && (reg_addr == xpr_pkg::ADDR_LEVEL);
  wire wr_ctl   = wr_stb && (reg_addr == xpr_pkg::ADDR_CONTROL); // see R15

  always_ff @(posedge clk) begin
    if (reset) begin
      route_q <= xpr_pkg::CFG_RESET;
      boost_q <= xpr_pkg::CFG_RESET;
      level_q <= xpr_pkg::CFG_RESET;
      ctl_q   <= xpr_pkg::CTL_RESET; // see R02
    end else begin
      if (wr_route) route_q <= wr_data;
      if (wr_boost) boost_q <= wr_data;
      if (wr_level) level_q <= wr_data; // see R16
      if (wr_ctl)   ctl_q   <= wr_data;
    end
  end

  // status has no write path, so a write there is a harmless no-op
  always_ff @(posedge clk) begin
    if (reset) status_q <= 4'h0; // see R13
    else       status_q <= valid_s; // see R13, R18
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      xpr_pkg::ADDR_SWITCH:  rd_mux = route_q;
      xpr_pkg::ADDR_BOOST:   rd_mux = boost_q;
      xpr_pkg::ADDR_LEVEL:   rd_mux = level_q;
      xpr_pkg::ADDR_CONTROL: rd_mux = ctl_q;
      xpr_pkg::ADDR_STATUS:  rd_mux = {xpr_pkg::STATUS_RESERVED, status_q}; // see R14, R15
      default:               rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb) rd_data <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power modes and enables

  wire       soft_power_down_n = ctl_q[xpr_pkg::CTL_SOFT_PD];
  wire       powered_d = pd_pin_n_s | soft_power_down_n; // see R07, R08
  wire       mon_en    = ctl_q[xpr_pkg::CTL_MON_EN];
  wire [3:0] used_in   = routed_inputs(route_q); // see R10
  wire [3:0] output_off_n = ctl_q[xpr_pkg::CTL_OUT_OFF_LSB +: 4];
  // monitors run in both modes when enabled; auto gating cannot override
  wire [3:0] mon_d   = {4{mon_en}}; // see R05, R06, R09
  wire [3:0] in_d    = powered_d ? (used_in | {4{mon_en}}) : mon_d; // see R08, R12
  wire [3:0] out_d   = powered_d ? output_off_n : 4'h0; // see R02, R11

  logic [15:0] rx_lvl_d;
  logic [7:0]  tx_lvl_d;
  always_comb begin
    for (int i = 0; i < xpr_pkg::NUM_PORTS; i++) begin
      rx_lvl_d[4*i +: 4] = ctl_q[xpr_pkg::CTL_OVR_LEVEL] ? level_decode(level_q[2*i +: 2])
                         : level_decode(lvl_pin_s[i] ? xpr_pkg::PIN_LEVEL_ON : xpr_pkg::LVL_CODE_OFF); // see R03
      tx_lvl_d[2*i +: 2] = ctl_q[xpr_pkg::CTL_OVR_BOOST] ? boost_q[2*i +: 2]
                         : (bst_pin_s[i] ? xpr_pkg::PIN_BOOST_ON : xpr_pkg::LVL_CODE_OFF); // see R04
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      core_powered    <= 1'b0;
      input_enable    <= 4'h0;
      monitor_enable  <= 4'h0;
      output_enable   <= 4'h0;
      rx_equalization <= 16'h0000;
      tx_pre_emphasis <= 8'h00;
      output_route    <= 8'h00;
    end else begin
      core_powered    <= powered_d;
      input_enable    <= in_d;
      monitor_enable  <= mon_d;
      output_enable   <= out_d;
      rx_equalization <= rx_lvl_d;
      tx_pre_emphasis <= tx_lvl_d;
      output_route    <= route_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  ctl_reset_a: assert property (@(posedge clk) // see R02
    $fell(reset)
    |-> ctl_q == xpr_pkg::CTL_RESET)
    else $error("control not at power-on value");

  out_gate_a: assert property (@(posedge clk) disable iff (reset) // see R11
    output_enable != 4'h0
    |-> $past(ctl_q[xpr_pkg::CTL_SOFT_PD] | pd_pin_n_s)
        && ((output_enable & ~$past(ctl_q[xpr_pkg::CTL_OUT_OFF_LSB +: 4])) == 4'h0))
    else $error("output enabled while off or powered down");

  out_map_a: assert property (@(posedge clk) disable iff (reset) // see R02, R11
    !$past(reset) && $past(powered_d)
    |-> output_enable == $past(ctl_q[xpr_pkg::CTL_OUT_OFF_LSB +: 4]))
    else $error("powered output enable not per bit");

  mon_all_a: assert property (@(posedge clk) disable iff (reset) // see R05, R06, R09
    !$past(reset) && $past(ctl_q[xpr_pkg::CTL_MON_EN])
    |-> monitor_enable == 4'hF && input_enable == 4'hF)
    else $error("monitor enable not honoured");

  mon_off_a: assert property (@(posedge clk) disable iff (reset) // see R05
    !$past(reset) && !$past(ctl_q[xpr_pkg::CTL_MON_EN])
    |-> monitor_enable == 4'h0)
    else $error("monitors on while disabled");

  pd_mode_a: assert property (@(posedge clk) disable iff (reset) // see R08
    !$past(reset) && !$past(ctl_q[xpr_pkg::CTL_SOFT_PD]) && !$past(pd_pin_n_s)
    |-> !core_powered && output_enable == 4'h0)
    else $error("power-down mode not entered");

  pwr_or_a: assert property (@(posedge clk) disable iff (reset) // see R07
    !$past(reset)
    |-> core_powered == ($past(ctl_q[xpr_pkg::CTL_SOFT_PD]) | $past(pd_pin_n_s)))
    else $error("power mode not or of pin and soft bit");

  unused_in_a: assert property (@(posedge clk) disable iff (reset) // see R10, R12
    !$past(reset) && !$past(ctl_q[xpr_pkg::CTL_MON_EN])
    |-> input_enable == ($past(powered_d) ? $past(used_in) : 4'h0))
    else $error("input gating wrong");

  route_copy_a: assert property (@(posedge clk) disable iff (reset) // see R10
    !$past(reset)
    |-> output_route == $past(route_q))
    else $error("route not forwarded");

  status_wr_a: assert property (@(posedge clk) disable iff (reset) // see R18
    wr_stb && reg_addr == xpr_pkg::ADDR_STATUS
    |=> status_q == $past(valid_s))
    else $error("status changed by write");

  level_decode_a: assert property (@(posedge clk) disable iff (reset) // see R01, R03
    !$past(reset) && $past(ctl_q[xpr_pkg::CTL_OVR_LEVEL]) && $past(level_q[1:0]) == xpr_pkg::LVL_CODE_HIGH
    |-> rx_equalization[3:0] == xpr_pkg::XPR_LVL_HIGH)
    else $error("equalization decode wrong");

  level_pin_a: assert property (@(posedge clk) disable iff (reset) // see R03
    !$past(reset) && !$past(ctl_q[xpr_pkg::CTL_OVR_LEVEL])
    |-> rx_equalization[3:0] == ($past(lvl_pin_s[0]) ? xpr_pkg::XPR_LVL_LOW : xpr_pkg::XPR_LVL_OFF))
    else $error("equalization pin level wrong");

  level_onehot_a: assert property (@(posedge clk) disable iff (reset) // see R01, R16
    !$past(reset)
    |-> $onehot(rx_equalization[3:0]) && $onehot(rx_equalization[7:4])
        && $onehot(rx_equalization[11:8]) && $onehot(rx_equalization[15:12]))
    else $error("equalization level not one-hot");

  boost_reg_a: assert property (@(posedge clk) disable iff (reset) // see R04
    !$past(reset) && $past(ctl_q[xpr_pkg::CTL_OVR_BOOST])
    |-> tx_pre_emphasis == $past(boost_q))
    else $error("pre-emphasis not from register");

  ctl_write_a: assert property (@(posedge clk) disable iff (reset) // see R15
    wr_stb && reg_addr == xpr_pkg::ADDR_CONTROL
    |=> ctl_q == $past(wr_data))
    else $error("control write lost");

  lvl_write_a: assert property (@(posedge clk) disable iff (reset) // see R16
    wr_stb && reg_addr == xpr_pkg::ADDR_LEVEL
    |=> level_q == $past(wr_data))
    else $error("equalization register write lost");

  rd_valid_a: assert property (@(posedge clk) disable iff (reset) // see R15
    !$past(reset)
    |-> rd_valid == $past(rd_stb))
    else $error("read valid not one cycle after strobe");

  rd_ctl_a: assert property (@(posedge clk) disable iff (reset) // see R15
    !$past(reset) && $past(rd_stb) && $past(reg_addr) == xpr_pkg::ADDR_CONTROL
    |-> rd_data == $past(ctl_q))
    else $error("control read data wrong");

  rd_status_a: assert property (@(posedge clk) disable iff (reset) // see R13, R14
    !$past(reset) && $past(rd_stb) && $past(reg_addr) == xpr_pkg::ADDR_STATUS
    |-> rd_data == {xpr_pkg::STATUS_RESERVED, $past(status_q)})
    else $error("status read data wrong");

endmodule : xpr_regs

`default_nettype wire

// file: rtl/xpr_pkg.sv
// xpr_pkg: constants for the crosspoint power and signal-loss register bank
// assumes: included before rtl/xpr_regs.sv, no other dependencies
package xpr_pkg;

  localparam int unsigned NUM_PORTS = 4;

  // register addresses as carried by the byte-wide register port
  localparam logic [7:0] ADDR_SWITCH  = 8'h00;
  localparam logic [7:0] ADDR_BOOST   = 8'h01;
  localparam logic [7:0] ADDR_LEVEL   = 8'h02;
  localparam logic [7:0] ADDR_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;

  // control register fields and power-on values
  localparam int unsigned CTL_OUT_OFF_LSB  = 0;
  localparam int unsigned CTL_OVR_LEVEL    = 4;
  localparam int unsigned CTL_OVR_BOOST    = 5;
  localparam int unsigned CTL_MON_EN       = 6;
  localparam int unsigned CTL_SOFT_PD      = 7;
  localparam logic [7:0]  CTL_RESET        = 8'h0F;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam logic [3:0]  STATUS_RESERVED  = 4'h0;

  // equalization and pre-emphasis level codes
  typedef enum logic [3:0] {
    XPR_LVL_OFF  = 4'h1,
    XPR_LVL_LOW  = 4'h2,
    XPR_LVL_MED  = 4'h4,
    XPR_LVL_HIGH = 4'h8
  } xpr_level_e;

  localparam logic [1:0] LVL_CODE_OFF  = 2'h0;
  localparam logic [1:0] LVL_CODE_LOW  = 2'h1;
  localparam logic [1:0] LVL_CODE_MED  = 2'h2;
  localparam logic [1:0] LVL_CODE_HIGH = 2'h3;

  // pin-selected levels: off or low for equalization, off or medium for boost
  localparam logic [1:0] PIN_LEVEL_ON  = 2'h1;
  localparam logic [1:0] PIN_BOOST_ON  = 2'h2;

endpackage : xpr_pkg

// file: verification/xpr_host.sv
// xpr_host: byte-level register host in place of the smbus front end
// assumes: testbench calls its tasks; design samples on rising clk
`timescale 1ns/1ps
`default_nettype none

module xpr_host (
  input  wire logic       clk,
  output var  logic       wr_stb,
  output var  logic       rd_stb,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] wr_data,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    wr_stb   = 1'b0;
    rd_stb   = 1'b0;
    reg_addr = 8'h00;
    wr_data  = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one pulse per finished write frame; released lines flip so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    wr_data  = d;
    wr_stb   = 1'b1;
    @(negedge clk);
    wr_stb   = 1'b0;
    reg_addr = ~a;
    wr_data  = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_addr = a;
    rd_stb   = 1'b1;
    @(negedge clk);
    rd_stb   = 1'b0;
    reg_addr = ~a;
    v        = rd_valid;
    d        = rd_data;
  endtask : rd
endmodule : xpr_host
`default_nettype wire

// file: verification/testbench.sv
// testbench: random register and pin settings against an integer model
// assumes: xpr_pkg and xpr_regs compiled first, host model in xpr_host
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0, reset = 1'b1, pd_n = 1'b1;
  logic [3:0] lvl_p = 4'h0, bst_p = 4'h0, sig_ok = 4'h0;
  logic wr_stb, rd_stb, rd_valid, powered;
  logic [7:0] reg_addr, wr_data, rd_data, tx_lvl, route;
  logic [3:0] in_en, mon_en, out_en;
  logic [15:0] rx_lvl;
  int error_cnt = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  xpr_host u_host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
  xpr_regs u_dut (.clk(clk), .reset(reset), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .power_down_pin_n(pd_n), .rx_level_pins(lvl_p), .tx_boost_pins(bst_p),
    .input_signal_valid(sig_ok), .input_enable(in_en), .monitor_enable(mon_en),
    .output_enable(out_en), .core_powered(powered), .rx_equalization(rx_lvl),
    .tx_pre_emphasis(tx_lvl), .output_route(route));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic [7:0] d;
    logic v;
    logic pw;
    logic [3:0] used;
    logic [1:0] c;
    logic [15:0] rx_lvl_x;
    logic [7:0] tx_lvl_x;
    int ctl, rt, lv, bo;
    void'($urandom(58));
    repeat (12) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    u_host.rd(8'h03, d, v);
    chk({v, d}, 16'h010F);
    u_host.rd(8'h04, d, v);
    chk({v, d}, 16'h0100);
    for (int i = 0; i < 40; i++) begin
      ctl = $urandom;
      rt = $urandom;
      lv = $urandom;
      bo = $urandom;
      // odd passes keep every output on so input gating is checked on every odd pass
      if (i % 2 == 1) ctl[3:0] = 4'hF;
      u_host.wr(8'h03, ctl[7:0]);
      u_host.wr(8'h00, rt[7:0]);
      u_host.wr(8'h02, lv[7:0]);
      u_host.wr(8'h01, bo[7:0]);
      u_host.wr(8'h04, 8'hFF);
      u_host.wr(8'(8'h05 + i), 8'h00);
      @(negedge clk);
      pd_n = 1'($urandom);
      lvl_p = 4'($urandom);
      bst_p = 4'($urandom);
      sig_ok = 4'($urandom);
      // pins pass synchronisers, so allow them to settle
      repeat (10) @(negedge clk);
      pw = pd_n | ctl[7];
      used = 4'h0;
      for (int o = 0; o < 4; o++) used[rt[2*o+:2]] = 1'b1;
      for (int k = 0; k < 4; k++) begin
        c = ctl[4] ? 2'(lv >> (2*k)) : {1'b0, lvl_p[k]};
        rx_lvl_x[4*k+:4] = 4'h1 << c;
        tx_lvl_x[2*k+:2] = ctl[5] ? 2'(bo >> (2*k)) : {bst_p[k], 1'b0};
      end
      chk(16'(powered), 16'(pw));
      chk(16'(mon_en), {12'h000, {4{ctl[6]}}});
      chk(16'(out_en), pw ? 16'(ctl[3:0]) : 16'h0000);
      if (ctl[6] || ctl[3:0] == 4'hF || !pw) chk(16'(in_en), ctl[6] ? 16'h000F : 16'(pw ? used : 4'h0));
      chk(rx_lvl, rx_lvl_x);
      chk(16'(tx_lvl), 16'(tx_lvl_x));
      chk(16'(route), 16'(rt[7:0]));
      u_host.rd(8'h03, d, v);
      chk({v, d}, {8'h01, ctl[7:0]});
      u_host.rd(8'h04, d, v);
      chk({v, d}, {12'h010, sig_ok});
      u_host.rd(8'(8'h05 + i), d, v);
      chk({v, d}, 16'h0100);
    end
    // second reset after the 40 random passes: status cleared and control back to power-on value together; status read first, then control
    @(negedge clk) reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    u_host.rd(8'h04, d, v);
    chk({v, d}, 16'h0100);
    u_host.rd(8'h03, d, v);
    chk({v, d}, 16'h010F);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
